//--- logic/hbs_pkg.sv
package hbs_pkg;

    // Decode windows are fixed when the design is built; software cannot move them.
    localparam logic [31:0] SRAM_BASE = 32'h0000_0000;
    localparam logic [31:0] SRAM_MASK = 32'hfff0_0000;
    localparam logic [31:0] BK_BASE   = 32'h0010_0000;
    localparam logic [31:0] BK_MASK   = 32'hfff0_0000;

    // Asynchronous SRAM wait states per beat, legal range 0 to 7.
    localparam logic [2:0] SRAM_WAIT = 3'h2;
    localparam logic [2:0] SYNC_WAIT = 3'h0;

    // Transfer type bits, counted from the least significant end of tt_i.
    localparam int TT_DATA_BIT = 1;
    localparam int TT_READ_BIT = 3;

    localparam int         BUF_DEPTH      = 4;
    localparam int         BUF_AW         = 2;
    localparam logic [1:0] BURST_LAST_IDX = 2'h3;
    localparam logic [1:0] SIZE_SINGLE    = 2'h0;
    localparam logic [1:0] SIZE_BURST     = 2'h3;
    localparam logic [7:0] BE_ALL_N       = 8'h00;
    localparam logic [7:0] BE_NONE_N      = 8'hff;

    typedef struct packed {
        logic [31:0] addr;
        logic        wr;
        logic        burst_n;
        logic [3:0]  tsiz;
    } hbs_req_s;

    typedef struct packed {
        logic [28:0] addr;
        logic [7:0]  we_n;
        logic        adsc_n;
        logic        adv_n;
        logic        cs_n;
        logic        oe_n;
    } hbs_ram_s;

    typedef struct packed {
        logic [28:0] addr;
        logic [7:0]  backend_byte_enable_n;
        logic        wr;
        logic [1:0]  size;
        logic        backend_last_beat_n;
        logic        req_n;
        logic [63:0] dout;
    } hbs_bk_s;

    localparam hbs_ram_s RAM_IDLE = '{29'h0, 8'hff, 1'b1, 1'b1, 1'b1, 1'b1};
    localparam hbs_bk_s  BK_IDLE  = '{29'h0, 8'hff, 1'b0, 2'h0, 1'b1, 1'b1, 64'h0};

    typedef enum logic [3:0] {
        A_IDLE = 4'h1, A_ACK = 4'h2, A_WIN = 4'h4, A_RTRY = 4'h8
    } hbs_astate_e;

    typedef enum logic [3:0] {
        S_IDLE = 4'h1, S_GRANT = 4'h2, S_BEAT = 4'h4, S_END = 4'h8
    } hbs_sstate_e;

    typedef enum logic [5:0] {
        B_IDLE = 6'h01, B_GRANT = 6'h02, B_WCAP = 6'h04,
        B_DRAIN = 6'h08, B_RREQ = 6'h10, B_RDONE = 6'h20
    } hbs_bstate_e;

endpackage : hbs_pkg

//--- logic/hbs_beat_ctr.sv
`timescale 1ns/1ps
module hbs_beat_ctr (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       load_i,
    input  wire logic       burst_n_i,
    input  wire logic [3:0] tsiz_i,
    input  wire logic [2:0] offs_i,
    input  wire logic       step_i,
    output logic      [1:0] idx_o,
    output logic            last_o,
    output logic      [7:0] be_n_o
);
    import hbs_pkg::*;

    logic [1:0]  idx_reg;
    logic [1:0]  lim_reg;
    logic [7:0]  be_reg;
    logic [3:0]  nbytes;
    logic [15:0] span;

    // A size of zero, or the extended size bit, means a full doubleword.
    assign nbytes = (tsiz_i[3] || tsiz_i[2:0] == 3'h0) ? 4'h8 : {1'b0, tsiz_i[2:0]};
    assign span   = ((16'h1 << nbytes) - 16'h1) << offs_i;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            idx_reg <= 2'h0;
            lim_reg <= 2'h0;
            be_reg  <= BE_NONE_N;
        end else if (load_i) begin
            idx_reg <= 2'h0;
            lim_reg <= burst_n_i ? 2'h0 : BURST_LAST_IDX;
            be_reg  <= burst_n_i ? ~span[7:0] : BE_ALL_N;
        end else if (step_i && idx_reg != lim_reg) begin
            idx_reg <= idx_reg + 2'h1;
        end
    end

    assign idx_o  = idx_reg;
    assign last_o = (idx_reg == lim_reg);
    assign be_n_o = be_reg;

endmodule : hbs_beat_ctr

//--- logic/hbs_post_buf.sv
`timescale 1ns/1ps
module hbs_post_buf (
    input  wire logic                       clk_i,
    input  wire logic                       wr_i,
    input  wire logic [hbs_pkg::BUF_AW-1:0] widx_i,
    input  wire logic [63:0]                wdata_i,
    input  wire logic [hbs_pkg::BUF_AW-1:0] ridx_i,
    output logic      [63:0]                rdata_o
);
    import hbs_pkg::*;

    logic [63:0] mem [BUF_DEPTH];

    always_ff @(posedge clk_i) begin
        if (wr_i) begin
            mem[widx_i] <= wdata_i;
        end
    end

    assign rdata_o = mem[ridx_i];

endmodule : hbs_post_buf

//--- logic/hbs_slave.sv
`timescale 1ns/1ps
module hbs_slave (
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic [31:0]      addr_i,
    input  wire logic             ts_n_i,
    input  wire logic [4:0]       tt_i,
    input  wire logic             tbst_n_i,
    input  wire logic [3:0]       tsiz_i,
    input  wire logic             dbg_n_i,
    input  wire logic             dbb_n_i,
    input  wire logic             aack_n_i,
    output logic                  aack_o,
    output logic                  aack_oe_o,
    input  wire logic             artry_n_i,
    output logic                  artry_o,
    output logic                  artry_oe_o,
    output logic                  ta_n_o,
    input  wire logic [63:0]      data_i,
    output logic      [63:0]      data_o,
    output logic                  data_oe_o,
    input  wire logic             ram_mode_i,
    output hbs_pkg::hbs_ram_s     ram_o,
    input  wire logic             backend_rdy_n_i,
    input  wire logic [63:0]      backend_din_i,
    output hbs_pkg::hbs_bk_s      backend_o
);
    import hbs_pkg::*;

    hbs_astate_e a_state;
    hbs_sstate_e s_state;
    hbs_bstate_e b_state;
    hbs_req_s    req_reg;
    hbs_req_s    s_req;
    hbs_req_s    b_req;
    hbs_req_s    b_src;
    hbs_ram_s    ram_reg;
    hbs_bk_s     bk_reg;
    logic        tgt_bk_reg;
    logic        data_reg;
    logic        od_low_reg;
    logic        aack_reg;
    logic        artry_reg;
    logic        ta_n_reg;
    logic [63:0] hdata_reg;
    logic        hoe_reg;
    logic        mode_s1;
    logic        mode_s2;
    logic [2:0]  wcnt;
    logic [2:0]  wait_lim;
    logic        hit_sram;
    logic        hit_bk;
    logic        is_data;
    logic        ts_take;
    logic        busy;
    logic        retry;
    logic        disp_s;
    logic        disp_b;
    logic        grant;
    logic        s_step;
    logic        s_last;
    logic [1:0]  s_idx;
    logic [7:0]  s_be;
    logic        b_step;
    logic        b_last;
    logic        b_load;
    logic        rd_beat;
    logic        bk_beat;
    logic        next_last;
    logic [1:0]  b_idx;
    logic [1:0]  ridx;
    logic [7:0]  b_be;
    logic [63:0] buf_rdata;

    assign hit_sram = (addr_i & SRAM_MASK) == SRAM_BASE;
    assign hit_bk   = (addr_i & BK_MASK) == BK_BASE;
    assign is_data  = tt_i[TT_DATA_BIT];
    assign ts_take  = a_state == A_IDLE && !ts_n_i && (hit_sram || hit_bk);
    // Only one host data tenure may be queued; the draining buffer is not one.
    assign busy     = s_state != S_IDLE || (b_state != B_IDLE && b_state != B_DRAIN);
    assign retry    = is_data && (busy || (hit_bk && b_state == B_DRAIN));
    assign disp_s   = a_state == A_WIN && artry_n_i && data_reg && !tgt_bk_reg;
    assign disp_b   = a_state == A_WIN && artry_n_i && data_reg && tgt_bk_reg;
    assign grant    = !dbg_n_i && dbb_n_i;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mode_s1 <= 1'b0;
            mode_s2 <= 1'b0;
        end else begin
            mode_s1 <= ram_mode_i;
            mode_s2 <= mode_s1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            a_state   <= A_IDLE;
            aack_reg  <= 1'b0;
            artry_reg <= 1'b0;
        end else begin
            unique case (a_state)
                A_IDLE: begin
                    if (ts_take) begin
                        aack_reg <= 1'b1;
                        if (retry) begin
                            artry_reg <= 1'b1;
                            a_state   <= A_RTRY;
                        end else begin
                            a_state <= A_ACK;
                        end
                    end
                end
                A_ACK: begin
                    aack_reg <= 1'b0;
                    a_state  <= A_WIN;
                end
                A_WIN: begin
                    a_state <= A_IDLE;
                end
                A_RTRY: begin
                    aack_reg  <= 1'b0;
                    artry_reg <= 1'b0;
                    a_state   <= A_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            req_reg    <= '0;
            tgt_bk_reg <= 1'b0;
            data_reg   <= 1'b0;
            od_low_reg <= 1'b0;
        end else if (ts_take) begin
            req_reg    <= '{addr_i, !tt_i[TT_READ_BIT], tbst_n_i, tsiz_i};
            tgt_bk_reg <= hit_bk;
            data_reg   <= is_data;
        end
    end

    hbs_beat_ctr u_sram_ctr (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .load_i    (disp_s),
        .burst_n_i (req_reg.burst_n),
        .tsiz_i    (req_reg.tsiz),
        .offs_i    (req_reg.addr[2:0]),
        .step_i    (s_step),
        .idx_o     (s_idx),
        .last_o    (s_last),
        .be_n_o    (s_be)
    );

    assign wait_lim = mode_s2 ? SYNC_WAIT : SRAM_WAIT;
    assign s_step   = s_state == S_BEAT && wcnt == wait_lim;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_state <= S_IDLE;
            s_req   <= '0;
            wcnt    <= 3'h0;
            ram_reg <= RAM_IDLE;
        end else begin
            unique case (s_state)
                S_IDLE: begin
                    if (disp_s) begin
                        s_req   <= req_reg;
                        s_state <= S_GRANT;
                    end
                end
                S_GRANT: begin
                    if (grant) begin
                        s_state        <= S_BEAT;
                        wcnt           <= 3'h0;
                        ram_reg.cs_n   <= 1'b0;
                        ram_reg.addr   <= s_req.addr[31:3];
                        ram_reg.oe_n   <= s_req.wr;
                        ram_reg.we_n   <= s_req.wr ? s_be : BE_NONE_N;
                        ram_reg.adsc_n <= !mode_s2;
                    end
                end
                S_BEAT: begin
                    ram_reg.adsc_n <= 1'b1;
                    ram_reg.adv_n  <= 1'b1;
                    if (s_step) begin
                        wcnt <= 3'h0;
                        if (s_last) begin
                            s_state <= S_END;
                        end else begin
                            ram_reg.addr  <= {s_req.addr[31:5], s_req.addr[4:3] + s_idx + 2'h1};
                            ram_reg.adv_n <= !mode_s2;
                        end
                    end else begin
                        wcnt <= wcnt + 3'h1;
                    end
                end
                S_END: begin
                    ram_reg <= RAM_IDLE;
                    s_state <= S_IDLE;
                end
            endcase
        end
    end

    // The counter is reloaded after capture so that the drain recounts the same beats.
    assign b_load  = disp_b || (b_state == B_WCAP && b_last);
    assign b_src   = disp_b ? req_reg : b_req;
    assign bk_beat = (b_state == B_DRAIN || b_state == B_RREQ) && !bk_reg.req_n
                     && !backend_rdy_n_i;
    assign rd_beat = bk_beat && b_state == B_RREQ;
    assign b_step  = b_state == B_WCAP || bk_beat;
    assign ridx    = (b_state == B_WCAP || b_state == B_GRANT) ? 2'h0 : b_idx + 2'h1;
    assign next_last = b_req.burst_n || ridx == BURST_LAST_IDX;

    hbs_beat_ctr u_bk_ctr (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .load_i    (b_load),
        .burst_n_i (b_src.burst_n),
        .tsiz_i    (b_src.tsiz),
        .offs_i    (b_src.addr[2:0]),
        .step_i    (b_step),
        .idx_o     (b_idx),
        .last_o    (b_last),
        .be_n_o    (b_be)
    );

    hbs_post_buf u_post_buf (
        .clk_i   (clk_i),
        .wr_i    (b_state == B_WCAP),
        .widx_i  (b_idx),
        .wdata_i (data_i),
        .ridx_i  (ridx),
        .rdata_o (buf_rdata)
    );

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            b_state <= B_IDLE;
            b_req   <= '0;
            bk_reg  <= BK_IDLE;
        end else begin
            unique case (b_state)
                B_IDLE: begin
                    if (disp_b) begin
                        b_req   <= req_reg;
                        b_state <= B_GRANT;
                    end
                end
                B_GRANT: begin
                    if (grant) begin
                        if (b_req.wr) begin
                            b_state <= B_WCAP;
                        end else begin
                            b_state                      <= B_RREQ;
                            bk_reg.req_n                 <= 1'b0;
                            bk_reg.wr                    <= 1'b0;
                            bk_reg.addr                  <= b_req.addr[31:3];
                            bk_reg.backend_byte_enable_n <= b_be;
                            bk_reg.size  <= b_req.burst_n ? SIZE_SINGLE : SIZE_BURST;
                            bk_reg.backend_last_beat_n   <= !next_last;
                        end
                    end
                end
                B_WCAP: begin
                    if (b_last) begin
                        b_state                      <= B_DRAIN;
                        bk_reg.req_n                 <= 1'b0;
                        bk_reg.wr                    <= 1'b1;
                        bk_reg.addr                  <= b_req.addr[31:3];
                        bk_reg.dout                  <= buf_rdata;
                        bk_reg.backend_byte_enable_n <= b_be;
                        bk_reg.size  <= b_req.burst_n ? SIZE_SINGLE : SIZE_BURST;
                        bk_reg.backend_last_beat_n   <= !next_last;
                    end
                end
                B_DRAIN, B_RREQ: begin
                    if (bk_beat) begin
                        if (b_last) begin
                            bk_reg.req_n               <= 1'b1;
                            bk_reg.backend_last_beat_n <= 1'b1;
                            b_state <= (b_state == B_DRAIN) ? B_IDLE : B_RDONE;
                        end else begin
                            bk_reg.addr <= {b_req.addr[31:5], b_req.addr[4:3] + ridx};
                            bk_reg.dout <= buf_rdata;
                            bk_reg.backend_last_beat_n <= !next_last;
                        end
                    end
                end
                B_RDONE: begin
                    b_state <= B_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            hdata_reg <= 64'h0;
            hoe_reg   <= 1'b0;
        end else begin
            hoe_reg <= rd_beat;
            if (rd_beat) begin
                hdata_reg <= backend_din_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ta_n_reg <= 1'b1;
        end else begin
            ta_n_reg <= !(s_step || rd_beat || (b_state == B_WCAP && !b_last)
                          || (b_state == B_GRANT && grant && b_req.wr));
        end
    end

    assign aack_o     = od_low_reg;
    assign artry_o    = od_low_reg;
    assign aack_oe_o  = aack_reg;
    assign artry_oe_o = artry_reg;
    assign ta_n_o     = ta_n_reg;
    assign data_o     = hdata_reg;
    assign data_oe_o  = hoe_reg;
    assign ram_o      = ram_reg;
    assign backend_o  = bk_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    retry_idle_a: assert property ($rose(artry_oe_o) |=> a_state == A_IDLE)
        else $error("address machine not idle one cycle after retry");
    claim_ack_a: assert property (ts_take |=> aack_oe_o ##1 !aack_oe_o)
        else $error("claimed tenure not acknowledged for one cycle");
    miss_ignore_a: assert property ((a_state == A_IDLE && !ts_n_i && !hit_sram && !hit_bk)
        |=> !aack_oe_o && !artry_oe_o)
        else $error("unmapped address was answered");
    drain_retry_a: assert property ((ts_take && is_data && hit_bk && b_state == B_DRAIN)
        |=> artry_oe_o && aack_oe_o)
        else $error("back-end request during drain not retried");
    sram_drain_a: assert property ((ts_take && is_data && hit_sram && !hit_bk
        && b_state == B_DRAIN && s_state == S_IDLE)
        |=> !artry_oe_o)
        else $error("SRAM access refused while buffer drains");
    sram_go_a: assert property ((ts_take && is_data && hit_sram && !hit_bk
        && b_state == B_DRAIN && s_state == S_IDLE) ##2 artry_n_i
        |=> s_state == S_GRANT)
        else $error("SRAM access not dispatched while buffer drains");
    grant_hold_a: assert property ((s_state == S_GRANT && !grant)
        |=> s_state == S_GRANT && ram_o.cs_n)
        else $error("SRAM transfer started without data bus grant");
    wcap_ta_a: assert property (b_state == B_WCAP |-> !ta_n_o)
        else $error("posted write beat took a wait state");
    rbuf_data_a: assert property (rd_beat
        |=> !ta_n_o && data_oe_o && data_o == $past(backend_din_i))
        else $error("read buffer data not presented with acknowledge");
    rdy_hold_a: assert property ((!backend_o.req_n && backend_rdy_n_i)
        |=> !backend_o.req_n && $stable(backend_o.addr))
        else $error("back-end beat ended without ready");
    ext_retry_a: assert property ((a_state == A_WIN && !artry_n_i && s_state == S_IDLE)
        |=> a_state == A_IDLE && s_state == S_IDLE)
        else $error("retried tenure was not abandoned");
    sram_end_a: assert property (s_state == S_END |=> s_state == S_IDLE && ram_o.cs_n)
        else $error("SRAM machine did not return to idle");
    sram_wait_a: assert property ((s_state == S_BEAT && wcnt != wait_lim) |=> ta_n_o)
        else $error("SRAM beat acknowledged before its wait states");
    last_beat_a: assert property ((bk_beat && !backend_o.backend_last_beat_n)
        |=> backend_o.req_n)
        else $error("back-end request continued past the last beat");

endmodule : hbs_slave

//--- sim/hbs_host_model.sv
`timescale 1ns/1ps
module hbs_host_model (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       ts_n_i,
    input  wire logic [4:0] tt_i,
    input  wire logic       aack_oe_i,
    input  wire logic       artry_oe_i,
    input  wire logic       frtry_i,
    output logic            dbg_n_o,
    output logic            dbb_n_o,
    output logic            aack_n_o,
    output logic            artry_n_o
);
    import hbs_pkg::*;
    logic [1:0] cnt_reg;
    logic       data_reg;
    assign aack_n_o  = !aack_oe_i;
    assign artry_n_o = !(artry_oe_i || frtry_i);
    // Grant is first offered while the bus is still busy, then once with the bus free.
    assign dbg_n_o = (cnt_reg == 2'h0);
    assign dbb_n_o = (cnt_reg == 2'h1);
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_reg  <= 2'h0;
            data_reg <= 1'b0;
        end else begin
            if (!ts_n_i) data_reg <= tt_i[TT_DATA_BIT];
            if (cnt_reg != 2'h0 && !artry_n_o) cnt_reg <= 2'h0;
            else if (aack_oe_i && !artry_oe_i && data_reg) cnt_reg <= 2'h3;
            else if (cnt_reg != 2'h0) cnt_reg <= cnt_reg - 2'h1;
        end
    end
endmodule : hbs_host_model

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import hbs_pkg::*;
    logic        clk_i, sys_rst_i, ts_n, tbst_n, frtry, ram_mode, rdy_n;
    logic        dbg_n, dbb_n, aack_n, artry_n, aack_oe, artry_oe, ta_n, data_oe, ack, rty;
    logic [31:0] addr;
    logic [4:0]  tt;
    logic [3:0]  tsiz;
    logic [63:0] data_i, data_o, din, pat;
    hbs_ram_s    ram, ta_ram[8];
    hbs_bk_s     bk, bk_d[4];
    logic [63:0] ta_dat[8];
    logic        ta_oe[8];
    int          cyc, g_cyc, r_cyc, ta_cnt, bk_n, bk_wait, rdy_cnt, n_errors, comparisons, ta_cyc[8];
    assign data_i = pat + 64'(ta_cnt);
    hbs_slave u_hbs_slave (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .ts_n_i(ts_n),
        .tt_i(tt), .tbst_n_i(tbst_n), .tsiz_i(tsiz), .dbg_n_i(dbg_n), .dbb_n_i(dbb_n),
        .aack_n_i(aack_n), .aack_o(), .aack_oe_o(aack_oe), .artry_n_i(artry_n), .artry_o(),
        .artry_oe_o(artry_oe), .ta_n_o(ta_n), .data_i(data_i), .data_o(data_o),
        .data_oe_o(data_oe), .ram_mode_i(ram_mode), .ram_o(ram), .backend_rdy_n_i(rdy_n),
        .backend_din_i(din), .backend_o(bk));
    hbs_host_model u_hbs_host_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ts_n_i(ts_n),
        .tt_i(tt), .aack_oe_i(aack_oe), .artry_oe_i(artry_oe), .frtry_i(frtry),
        .dbg_n_o(dbg_n), .dbb_n_o(dbb_n), .aack_n_o(aack_n), .artry_n_o(artry_n));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (dbg_n === 1'b0 && dbb_n === 1'b1) g_cyc <= cyc;
        if (ta_n === 1'b0) begin
            ta_cyc[ta_cnt%8] <= cyc;
            ta_dat[ta_cnt%8] <= data_o;
            ta_oe[ta_cnt%8]  <= data_oe;
            ta_ram[ta_cnt%8] <= ram;
            ta_cnt <= ta_cnt + 1;
        end
        if (bk.req_n === 1'b0 && rdy_n === 1'b0) begin
            bk_d[bk_n%4] <= bk;
            r_cyc <= cyc;
            bk_n <= bk_n + 1;
        end
    end
    // Back-end device: ready after bk_wait idle cycles; data is inverted when not ready.
    always @(posedge clk_i) begin
        #1;
        if (bk.req_n === 1'b0 && rdy_cnt < bk_wait) begin
            rdy_cnt++;
            rdy_n = 1'b1;
        end else if (bk.req_n === 1'b0 && rdy_n) rdy_n = 1'b0;
        else begin
            rdy_n = 1'b1;
            rdy_cnt = 0;
        end
        din = rdy_n ? ~pat : pat;
    end
    task chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task conclude;
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    task clr;
        ta_cnt = 0;
        bk_n = 0;
    endtask : clr
    task at(input logic [31:0] a, input logic rd, input logic dat, input logic bn, input logic f);
        addr = a;
        tt = 5'h0;
        tt[TT_READ_BIT] = rd;
        tt[TT_DATA_BIT] = dat;
        tbst_n = bn;
        ts_n = 1'b0;
        @(posedge clk_i);
        #1;
        ts_n = 1'b1;
        addr = ~a;
        ack = aack_oe;
        rty = artry_oe;
        @(posedge clk_i);
        #1;
        frtry = f;
        @(posedge clk_i);
        #1;
        frtry = 1'b0;
    endtask : at
    task wta(input int n);
        for (int k = 0; k < 300 && ta_cnt < n; k++) begin
            @(posedge clk_i);
            #1;
        end
        chk(64'(ta_cnt), 64'(n));
    endtask : wta
    task sram(input logic rd, input logic bn, input int n, input int w);
        clr;
        at(32'h0000_0100, rd, 1'b1, bn, 1'b0);
        chk(ack, 1'b1);
        chk(rty, 1'b0);
        wta(n);
        chk(64'(ta_cyc[0] - g_cyc), 64'(2 + w));
        chk(ta_ram[0].cs_n, 1'b0);
        if (rd) chk(ta_ram[0].oe_n, 1'b0);
        else chk(ta_ram[0].we_n, BE_ALL_N);
        $display("test sram rd=%0b beats=%0d done", rd, n);
    endtask : sram
    task t_bk_wr;
        clr;
        pat = 64'h5a5a_0000_0000_0010;
        bk_wait = 8;
        at(BK_BASE + 32'h40, 1'b0, 1'b1, 1'b0, 1'b0);
        chk(ack, 1'b1);
        wta(4);
        chk(64'(ta_cyc[0] - g_cyc), 64'h1);
        chk(64'(ta_cyc[3] - g_cyc), 64'h4);
        at(SRAM_BASE + 32'h200, 1'b1, 1'b1, 1'b1, 1'b0);
        chk(rty, 1'b0);
        wta(5);
        at(BK_BASE + 32'h80, 1'b1, 1'b1, 1'b1, 1'b0);
        chk(rty, 1'b1);
        for (int k = 0; k < 400 && bk_n < 4; k++) @(posedge clk_i);
        #1;
        for (int k = 0; k < 4; k++) begin
            chk(bk_d[k].dout, pat + 64'(k));
            chk(bk_d[k].backend_last_beat_n, k != 3);
            chk({bk_d[k].wr, bk_d[k].size, bk_d[k].backend_byte_enable_n},
                {1'b1, SIZE_BURST, BE_ALL_N});
        end
        repeat (10) @(posedge clk_i);
        #1;
        chk(64'(ta_cnt), 64'h5);
        $display("test backend write done");
    endtask : t_bk_wr
    task t_bk_rd;
        clr;
        pat = 64'hc3c3_1234_5678_9abc;
        bk_wait = 3;
        at(BK_BASE + 32'h8, 1'b1, 1'b1, 1'b1, 1'b0);
        chk(ack, 1'b1);
        wta(1);
        chk(64'(ta_cyc[0] - r_cyc), 64'h1);
        chk(ta_dat[0], pat);
        chk(ta_oe[0], 1'b1);
        chk({bk_d[0].wr, bk_d[0].size, bk_d[0].backend_last_beat_n}, {1'b0, SIZE_SINGLE, 1'b0});
        $display("test backend read done");
    endtask : t_bk_rd
    task t_addr;
        clr;
        at(SRAM_BASE + 32'h300, 1'b0, 1'b0, 1'b1, 1'b0);
        chk({ack, rty}, 2'b10);
        at(32'h0020_0000, 1'b1, 1'b1, 1'b1, 1'b0);
        chk(ack, 1'b0);
        at(BK_BASE + 32'h10, 1'b1, 1'b1, 1'b1, 1'b1);
        chk(ack, 1'b1);
        repeat (20) @(posedge clk_i);
        #1;
        chk(64'(ta_cnt + bk_n), 64'h0);
        at(SRAM_BASE + 32'h400, 1'b1, 1'b1, 1'b1, 1'b0);
        chk({ack, rty}, 2'b10);
        wta(1);
        $display("test address tenure done");
    endtask : t_addr
    initial begin
        {ts_n, tbst_n, rdy_n, sys_rst_i} = 4'hf;
        {frtry, ram_mode, addr, tt, tsiz, pat, din} = '0;
        {cyc, g_cyc, r_cyc, ta_cnt, bk_n, bk_wait, rdy_cnt, n_errors, comparisons} = '0;
        repeat (20) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        sram(1'b1, 1'b1, 1, SRAM_WAIT);
        sram(1'b0, 1'b0, 4, SRAM_WAIT);
        ram_mode = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        sram(1'b1, 1'b1, 1, SYNC_WAIT);
        ram_mode = 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        t_bk_wr;
        t_bk_rd;
        t_addr;
        conclude;
    end
    initial begin
        #(5 * 20000);
        n_errors++;
        conclude;
    end
endmodule : tb_top
